/* File: inc/vfc_pkg.sv */
// Purpose: shared constants and types of the vector fp class and compare datapath
// Assumes: one lane evaluated per request, 64 lanes per wave
// Notes:   register offsets are byte addresses on a 32-bit apb bus
`default_nettype none
package vfc_pkg;
    localparam int LANES = 64;
    localparam int LANE_W = 6;
    localparam int ADDR_W = 8;

    typedef enum logic [1:0] {PREC_HALF, PREC_SINGLE, PREC_DOUBLE} vfc_prec_t;
    typedef enum logic [4:0] {
        OP_CLASS, OP_F, OP_LT, OP_EQ, OP_LE, OP_GT, OP_LG, OP_GE, OP_O, OP_U,
        OP_NGE, OP_NLG, OP_NGT, OP_NLE, OP_NEQ, OP_NLT, OP_T
    } vfc_op_t;

    // float field layout
    localparam int HP_SIGN = 15;
    localparam int HP_EXP_LO = 10;
    localparam int SP_SIGN = 31;
    localparam int SP_EXP_LO = 23;
    localparam int DP_SIGN = 63;
    localparam int DP_EXP_LO = 52;
    localparam logic [10:0] HP_EXP_MAX = 11'h01F;
    localparam logic [10:0] SP_EXP_MAX = 11'h0FF;
    localparam logic [10:0] DP_EXP_MAX = 11'h7FF;
    localparam logic [10:0] HP_EXP_INF = 11'h01F;  // 31
    localparam logic [10:0] SP_EXP_INF = 11'h0FF;  // 255
    localparam logic [10:0] DP_EXP_INF = 11'h3FF;  // 1023, kept as the class test defines it

    // class selection bits of the second operand
    localparam int CLS_SNAN = 0;
    localparam int CLS_QNAN = 1;
    localparam int CLS_NINF = 2;
    localparam int CLS_NNORM = 3;
    localparam int CLS_NDEN = 4;
    localparam int CLS_NZERO = 5;
    localparam int CLS_PZERO = 6;
    localparam int CLS_PDEN = 7;
    localparam int CLS_PNORM = 8;
    localparam int CLS_PINF = 9;

    typedef struct packed {
        logic        sign;
        logic [10:0] exp;
        logic [51:0] man;
        logic        nan;
        logic        snan;
    } vfc_fp_t;

    // apb register map
    localparam logic [ADDR_W-1:0] REG_EXECUTION_MASK_LOW_HALF = 8'h00;
    localparam logic [ADDR_W-1:0] REG_EXECUTION_MASK_HI = 8'h04;
    localparam logic [ADDR_W-1:0] REG_VCC_LO  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_VCC_HI  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IMASK   = 8'h14;
    localparam int EV_INVALID = 0;
    localparam int EV_DONE = 1;
    localparam int EV_W = 2;
    localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;
endpackage
`default_nettype wire

/* File: src/vfc_compare.sv */
// Purpose: per-lane fp class test and compare unit writing condition and execution masks
// Assumes: issuer presents one lane per cycle; registers reached over apb
// Notes:   result lands one cycle after the request; apb answers with one wait state
//
// How it works
// - class test true when operand category is enabled in ten-bit selection mask
// - signaling nan checked first, then quiet nan, then inf, normal, denormal, zero
// - half: non-nan exponent 31 is infinity, other nonzero exponent normal
// - single: non-nan exponent 255 is infinity, other nonzero exponent normal
// - double: non-nan exponent equal 1023 is infinity, other nonzero normal
// - sign picks bit: -inf 2, +inf 9, -normal 3, +normal 8
// - sign picks bit: -denormal 4, +denormal 7, -zero 5, +zero 6
// - zero exponent: denormal when magnitude nonzero, else signed zero
// - class result goes to lane bit of 64-bit condition mask
// - invalid raised on signaling nan, and on quiet nan with clamp set
// - execution-mask compares write only the execution mask lane bit
// - ordered compares give lt, eq, le, gt, ge of the two operands
// - less-or-greater true only when strictly less or strictly greater
// - orderable true only when neither widened operand is nan
// - unordered true when at least one operand is nan
// - negated compares invert their ordered counterpart, so nan gives true
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none
module vfc_compare
    import vfc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              req_valid,
    input  wire vfc_op_t           req_op,
    input  wire vfc_prec_t         req_prec,
    input  wire logic [LANE_W-1:0] req_lane,
    input  wire logic [63:0]       req_a,
    input  wire logic [63:0]       req_b,
    input  wire logic              req_clamp,
    output logic [LANES-1:0]       vcc_mask,
    output logic [LANES-1:0]       execution_mask_mask,
    output logic                   done,
    output logic                   invalid,
    output logic                   irq
);
    // split a raw operand into sign, exponent, right-aligned mantissa and nan flags
    function automatic vfc_fp_t fp_split(input vfc_prec_t prec, input logic [63:0] v);
        vfc_fp_t     f;
        logic [10:0] emax;
        logic        qbit;
        f = '0;
        emax = DP_EXP_MAX;
        qbit = 1'b0;
        unique case (prec)
            PREC_HALF: begin
                f.sign = v[HP_SIGN];
                f.exp = {6'h00, v[HP_SIGN-1:HP_EXP_LO]};
                f.man = {42'h0, v[HP_EXP_LO-1:0]};
                emax = HP_EXP_MAX;
                qbit = v[HP_EXP_LO-1];
            end
            PREC_SINGLE: begin
                f.sign = v[SP_SIGN];
                f.exp = {3'h0, v[SP_SIGN-1:SP_EXP_LO]};
                f.man = {29'h0, v[SP_EXP_LO-1:0]};
                emax = SP_EXP_MAX;
                qbit = v[SP_EXP_LO-1];
            end
            default: begin
                f.sign = v[DP_SIGN];
                f.exp = v[DP_SIGN-1:DP_EXP_LO];
                f.man = v[DP_EXP_LO-1:0];
                emax = DP_EXP_MAX;
                qbit = v[DP_EXP_LO-1];
            end
        endcase
        // widening keeps nan-ness and the quiet bit, so the test runs on native fields
        f.nan = (f.exp == emax) && (f.man != '0);
        f.snan = f.nan && !qbit;
        return f;
    endfunction

    // selection bit index for the class test
    function automatic logic [3:0] fp_class(input vfc_prec_t prec, input vfc_fp_t f);
        logic [10:0] einf;
        logic [3:0]  idx;
        unique case (prec)
            PREC_HALF:   einf = HP_EXP_INF;
            PREC_SINGLE: einf = SP_EXP_INF;
            default:     einf = DP_EXP_INF;
        endcase
        if (f.snan) begin
            idx = 4'(CLS_SNAN);
        end else if (f.nan) begin
            idx = 4'(CLS_QNAN);
        end else if (f.exp == einf) begin
            idx = f.sign ? 4'(CLS_NINF) : 4'(CLS_PINF);
        end else if (f.exp != '0) begin
            idx = f.sign ? 4'(CLS_NNORM) : 4'(CLS_PNORM);
        end else if (f.man != '0) begin
            idx = f.sign ? 4'(CLS_NDEN) : 4'(CLS_PDEN);
        end else begin
            idx = f.sign ? 4'(CLS_NZERO) : 4'(CLS_PZERO);
        end
        return idx;
    endfunction

    // ordered relations, all false when either side is nan
    function automatic logic fp_less(input vfc_fp_t a, input vfc_fp_t b);
        logic [62:0] ma;
        logic [62:0] mb;
        ma = {a.exp, a.man};
        mb = {b.exp, b.man};
        if (a.nan || b.nan || (ma == '0 && mb == '0)) begin
            return 1'b0;
        end else if (a.sign != b.sign) begin
            return a.sign;
        end else begin
            return a.sign ? (ma > mb) : (ma < mb);
        end
    endfunction

    function automatic logic fp_equal(input vfc_fp_t a, input vfc_fp_t b);
        logic [62:0] ma;
        logic [62:0] mb;
        ma = {a.exp, a.man};
        mb = {b.exp, b.man};
        if (a.nan || b.nan) begin
            return 1'b0;
        end else begin
            return (ma == '0 && mb == '0) || (a.sign == b.sign && ma == mb);
        end
    endfunction

    vfc_fp_t         fa;
    vfc_fp_t         fb;
    logic [3:0]      cls_idx;
    logic            lt;
    logic            eq;
    logic            gt;
    logic            unord;
    logic            result;
    logic            raise_inv;
    logic [LANES-1:0] lane_bit;
    logic [LANES-1:0] vcc_r;
    logic [LANES-1:0] execution_mask_r;
    logic [EV_W-1:0]  status_r;
    logic [EV_W-1:0]  imask_r;
    logic [EV_W-1:0]  status_nxt;
    logic            done_r;
    logic            invalid_r;
    logic            irq_r;
    logic            pready_r;
    logic [31:0]     prdata_r;
    logic            pslverr_r;
    logic            apb_acc;
    logic            apb_wr;
    logic            addr_ok;
    logic [31:0]     rd_word;

    always_comb begin
        fa = fp_split(req_prec, req_a);
        fb = fp_split(req_prec, req_b);
        cls_idx = fp_class(req_prec, fa);
        lt = fp_less(fa, fb);
        eq = fp_equal(fa, fb);
        gt = fp_less(fb, fa);
        unord = fa.nan || fb.nan;
        lane_bit = LANES'(1) << req_lane;
    end

    always_comb begin
        unique case (req_op)
            OP_CLASS: result = req_b[cls_idx];
            OP_F:     result = 1'b0;
            OP_T:     result = 1'b1;
            OP_LT:    result = lt;
            OP_EQ:    result = eq;
            OP_LE:    result = lt || eq;
            OP_GT:    result = gt;
            OP_GE:    result = gt || eq;
            OP_LG:    result = lt || gt;
            OP_O:     result = !unord;
            OP_U:     result = unord;
            OP_NGE:   result = !(gt || eq);
            OP_NLG:   result = !(lt || gt);
            OP_NGT:   result = !gt;
            OP_NLE:   result = !(lt || eq);
            OP_NEQ:   result = !eq;
            OP_NLT:   result = !lt;
            default:  result = 1'b0;
        endcase
    end

    // the class test's second operand is a selection mask, not a float
    always_comb begin
        if (req_op == OP_CLASS) begin
            raise_inv = fa.snan || (req_clamp && fa.nan);
        end else begin
            raise_inv = fa.snan || fb.snan || (req_clamp && unord);
        end
    end

    // apb decode
    always_comb begin
        apb_acc = psel && penable && !pready_r;
        addr_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            REG_EXECUTION_MASK_LOW_HALF: rd_word = execution_mask_r[31:0];
            REG_EXECUTION_MASK_HI: rd_word = execution_mask_r[63:32];
            REG_VCC_LO:  rd_word = vcc_r[31:0];
            REG_VCC_HI:  rd_word = vcc_r[63:32];
            REG_STATUS:  rd_word = {30'h0, status_r};
            REG_IMASK:   rd_word = {30'h0, imask_r};
            default:     addr_ok = 1'b0;
        endcase
        // decoded after the case so an unmapped write never sees a stale address match
        apb_wr = apb_acc && pwrite && addr_ok;
    end

    // condition mask: class results only
    always_ff @(posedge mclk) begin
        if (srst) begin
            vcc_r <= MASK_RESET;
        end else if (req_valid && req_op == OP_CLASS) begin
            vcc_r <= result ? (vcc_r | lane_bit) : (vcc_r & ~lane_bit);
        end
    end

    // execution mask: software may seed it, a compare in the same cycle wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            execution_mask_r <= MASK_RESET;
        end else if (req_valid && req_op != OP_CLASS) begin
            execution_mask_r <= result ? (execution_mask_r | lane_bit) : (execution_mask_r & ~lane_bit);
        end else if (apb_wr && paddr == REG_EXECUTION_MASK_LOW_HALF) begin
            execution_mask_r[31:0] <= pwdata;
        end else if (apb_wr && paddr == REG_EXECUTION_MASK_HI) begin
            execution_mask_r[63:32] <= pwdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            done_r <= 1'b0;
            invalid_r <= 1'b0;
        end else begin
            done_r <= req_valid;
            invalid_r <= req_valid && raise_inv;
        end
    end

    // sticky events: a new event beats a write-one clear in the same cycle
    always_comb begin
        status_nxt = status_r;
        if (apb_wr && paddr == REG_STATUS) begin
            status_nxt = status_r & ~pwdata[EV_W-1:0];
        end
        if (req_valid && raise_inv) begin
            status_nxt[EV_INVALID] = 1'b1;
        end
        if (req_valid) begin
            status_nxt[EV_DONE] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_r <= EV_RESET;
            imask_r <= EV_RESET;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (apb_wr && paddr == REG_IMASK) begin
                imask_r <= pwdata[EV_W-1:0];
                irq_r <= |(status_nxt & pwdata[EV_W-1:0]);
            end else begin
                irq_r <= |(status_nxt & imask_r);
            end
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_acc;
            pslverr_r <= apb_acc && !addr_ok;
            prdata_r <= (apb_acc && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign vcc_mask = vcc_r;
    assign execution_mask_mask = execution_mask_r;
    assign done = done_r;
    assign invalid = invalid_r;
    assign irq = irq_r;

    a_class_snan: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS && fa.snan)
        |=> vcc_r[$past(req_lane)] == $past(req_b[CLS_SNAN]))
        else $error("class snan did not select bit 0");

    a_class_half_inf: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS && req_prec == PREC_HALF
         && req_a[HP_SIGN-1:HP_EXP_LO] == HP_EXP_INF[4:0] && req_a[HP_EXP_LO-1:0] == '0)
        |=> vcc_r[$past(req_lane)]
            == $past(req_b[req_a[HP_SIGN] ? CLS_NINF : CLS_PINF]))
        else $error("half infinity misclassified");

    a_class_single_inf: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS && req_prec == PREC_SINGLE
         && req_a[SP_SIGN-1:SP_EXP_LO] == SP_EXP_INF[7:0] && req_a[SP_EXP_LO-1:0] == '0)
        |=> vcc_r[$past(req_lane)]
            == $past(req_b[req_a[SP_SIGN] ? CLS_NINF : CLS_PINF]))
        else $error("single infinity misclassified");

    a_class_double_inf: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS && req_prec == PREC_DOUBLE
         && req_a[DP_SIGN-1:DP_EXP_LO] == DP_EXP_INF)
        |=> vcc_r[$past(req_lane)]
            == $past(req_b[req_a[DP_SIGN] ? CLS_NINF : CLS_PINF]))
        else $error("double exponent 1023 not classed as infinity");

    a_class_zero: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS && req_prec == PREC_HALF
         && req_a[HP_SIGN-1:0] == '0)
        |=> vcc_r[$past(req_lane)]
            == $past(req_b[req_a[HP_SIGN] ? CLS_NZERO : CLS_PZERO]))
        else $error("half zero misclassified");

    a_class_lane_only: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_CLASS)
        |=> ((vcc_r ^ $past(vcc_r)) & ~$past(lane_bit)) == '0 && $stable(execution_mask_r))
        else $error("class test touched another bit");

    a_execution_mask_only: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op != OP_CLASS) |=> $stable(vcc_r)
            && ((execution_mask_r ^ $past(execution_mask_r)) & ~$past(lane_bit)) == '0)
        else $error("execution_mask compare wrote beyond its lane bit");

    a_invalid_snan: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op != OP_CLASS && (fa.snan || fb.snan))
        |=> invalid_r ##0 status_r[EV_INVALID])
        else $error("snan operand did not raise invalid");

    a_unord_nan: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_U && fa.nan) |=> execution_mask_r[$past(req_lane)])
        else $error("unordered compare missed a nan");

    a_lg_equal: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op == OP_LG && req_a == req_b)
        |=> !execution_mask_r[$past(req_lane)])
        else $error("less-or-greater true on equal operands");

    a_negate_nan: assert property (@(posedge mclk) disable iff (srst)
        (req_valid && req_op inside {OP_NGE, OP_NLG, OP_NGT, OP_NLE, OP_NEQ, OP_NLT}
         && (fa.nan || fb.nan)) |=> execution_mask_r[$past(req_lane)])
        else $error("negated compare false on nan");
endmodule
`default_nettype wire

/* File: verif/vfc_issuer.sv */
// Purpose: issuer model driving lane requests into the compare unit
// Assumes: one request per call, launched just after a rising edge
// Notes:   released operands go inverted so a stale value never looks valid
`default_nettype none
module vfc_issuer
    import vfc_pkg::*;
(
    input  wire logic              mclk,
    output var logic               req_valid,
    output var vfc_op_t            req_op,
    output var vfc_prec_t          req_prec,
    output var logic [LANE_W-1:0]  req_lane,
    output var logic [63:0]        req_a,
    output var logic [63:0]        req_b,
    output var logic               req_clamp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid = 1'b0;
        req_op = OP_F;
        req_prec = PREC_HALF;
        req_lane = 6'h00;
        req_a = 64'h0000_0000_0000_0000;
        req_b = 64'h0000_0000_0000_0000;
        req_clamp = 1'b0;
    end

    // destination follows the op: class tests write the condition mask, compares the execution mask, not a pin here
    task automatic send(input vfc_op_t op, input vfc_prec_t p, input logic [5:0] ln,
                        input logic [63:0] a, input logic [63:0] b, input logic c);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_op <= op;
        req_prec <= p;
        req_lane <= ln;
        req_a <= a;
        req_b <= b;
        req_clamp <= c;
        @(posedge mclk);
        req_valid <= 1'b0;
        req_a <= ~a;
        req_b <= ~b;
    endtask
endmodule
`default_nettype wire

/* File: verif/vfc_compare_test.sv */
// Purpose: self-checking bench of the fp class and compare unit
// Assumes: apb answers within 16 cycles, lane results one cycle after a request
// Notes:   reference model works on raw bit fields, never on design logic
`default_nettype none
module vfc_compare_test
    import vfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              req_valid, req_clamp, done, invalid, irq;
    vfc_op_t           req_op;
    vfc_prec_t         req_prec;
    logic [LANE_W-1:0] req_lane;
    logic [63:0]       req_a, req_b, vcc_mask, execution_mask_mask, sh_execution_mask, sh_vcc, a, b;
    int                fails, comparisons, seed, o;
    vfc_prec_t         p;
    logic [15:0] th [11] = '{16'h0000, 16'h8000, 16'h3C00, 16'hBC00, 16'h7C00, 16'hFC00,
        16'h7E00, 16'h7D00, 16'h0001, 16'h8001, 16'h4000};
    logic [31:0] ts [11] = '{32'h0000_0000, 32'h8000_0000, 32'h3F80_0000, 32'hBF80_0000,
        32'h7F80_0000, 32'hFF80_0000, 32'h7FC0_0000, 32'h7FA0_0000, 32'h0000_0001,
        32'h8000_0001, 32'h4000_0000};
    // exp 1023 and true exp 2047 both on purpose: the class test keys infinity on 1023
    logic [63:0] td [11] = '{64'h0000_0000_0000_0000, 64'h8000_0000_0000_0000,
        64'h3FF0_0000_0000_0000, 64'hBFF0_0000_0000_0000, 64'h7FF0_0000_0000_0000,
        64'hFFF0_0000_0000_0000, 64'h7FF8_0000_0000_0000, 64'h7FF4_0000_0000_0000,
        64'h0000_0000_0000_0001, 64'h8000_0000_0000_0001, 64'h4000_0000_0000_0000};

    vfc_compare uut (.mclk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
        .prdata, .pslverr, .req_valid, .req_op, .req_prec, .req_lane, .req_a, .req_b,
        .req_clamp, .vcc_mask, .execution_mask_mask, .done, .invalid, .irq);
    vfc_issuer u_iss (.mclk, .req_valid, .req_op, .req_prec, .req_lane, .req_a, .req_b,
        .req_clamp);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic int cls(input vfc_prec_t p, input logic [63:0] x);
        logic [10:0] e, emax, einf;
        logic [51:0] m;
        logic        s, q;
        case (p)
            PREC_HALF: {s, e, m, q, emax, einf} = {x[15], 6'h0, x[14:10], 42'h0, x[9:0],
                x[9], 11'h01F, 11'h01F};
            PREC_SINGLE: {s, e, m, q, emax, einf} = {x[31], 3'h0, x[30:23], 29'h0,
                x[22:0], x[22], 11'h0FF, 11'h0FF};
            default: {s, e, m, q, emax, einf} = {x[63:0], x[51], 11'h7FF, 11'h3FF};
        endcase
        if (e == emax && m != 0) return q ? 1 : 0;
        if (e == einf) return s ? 2 : 9;
        if (e != 0) return s ? 3 : 8;
        if (m != 0) return s ? 4 : 7;
        return s ? 5 : 6;
    endfunction

    function automatic longint key(input vfc_prec_t p, input logic [63:0] x);
        longint m;
        m = p == PREC_HALF ? {49'h0, x[14:0]} : p == PREC_SINGLE ? {33'h0, x[30:0]} : x[62:0];
        return (p == PREC_HALF ? x[15] : p == PREC_SINGLE ? x[31] : x[63]) ? -m : m;
    endfunction

    function automatic logic cmp(input vfc_op_t op, input vfc_prec_t p,
                                 input logic [63:0] a, input logic [63:0] b);
        logic un, lt, eq, gt;
        un = cls(p, a) < 2 || cls(p, b) < 2;
        lt = !un && key(p, a) < key(p, b);
        eq = !un && key(p, a) == key(p, b);
        gt = !un && key(p, a) > key(p, b);
        case (op)
            OP_LT: return lt;
            OP_EQ: return eq;
            OP_LE: return lt | eq;
            OP_GT: return gt;
            OP_GE: return gt | eq;
            OP_LG: return lt | gt;
            OP_O: return !un;
            OP_U: return un;
            OP_NGE: return !(gt | eq);
            OP_NLG: return !(lt | gt);
            OP_NGT: return !gt;
            OP_NLE: return !(lt | eq);
            OP_NEQ: return !eq;
            OP_NLT: return !lt;
            OP_T: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [63:0] pick(input vfc_prec_t p, input int i);
        return p == PREC_HALF ? {48'h0, th[i]} : p == PREC_SINGLE ? {32'h0, ts[i]} : td[i];
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (n >= 16) chk("pready", 64'h0, 64'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp, input logic e);
        apb(1'b0, ad, 32'h0000_0000);
        chk("prdata", {32'h0, rd}, {32'h0, exp});
        chk("pslverr", {63'h0, err}, {63'h0, e});
    endtask

    task automatic run(input vfc_op_t op, input vfc_prec_t p, input logic [5:0] ln,
                       input logic [63:0] a, input logic [63:0] b, input logic c);
        int ca, cb;
        logic inv;
        ca = cls(p, a);
        cb = op == OP_CLASS ? 9 : cls(p, b);
        if (op == OP_CLASS) sh_vcc[ln] = b[ca];
        else sh_execution_mask[ln] = cmp(op, p, a, b);
        u_iss.send(op, p, ln, a, b, c);
        #1;
        chk("done", {63'h0, done}, 64'h1);
        inv = ca == 0 || cb == 0 || (c && (ca == 1 || cb == 1));
        chk("invalid", {63'h0, invalid}, {63'h0, inv});
        chk("vcc_mask", vcc_mask, sh_vcc);
        chk("vcc_lane", {63'h0, vcc_mask[ln]}, {63'h0, sh_vcc[ln]});
        chk("execution_mask_mask", execution_mask_mask, sh_execution_mask);
        chk("execution_mask_lane", {63'h0, execution_mask_mask[ln]}, {63'h0, sh_execution_mask[ln]});
    endtask

    initial begin
        #(50 * 60000);
        fails++;
        test_done;
    end

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {fails, comparisons, seed, sh_execution_mask, sh_vcc} = {32'd0, 32'd0, 32'd61, 128'h0};
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        for (int r = 0; r < 6; r++) rdchk(8'(4 * r), 32'h0000_0000, 1'b0);
        rdchk(8'h18, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk("pslverr", {63'h0, err}, 64'h1);
        apb(1'b1, REG_EXECUTION_MASK_LOW_HALF, 32'hA5A5_5A5A);
        apb(1'b1, REG_EXECUTION_MASK_HI, 32'h0F0F_F0F0);
        apb(1'b1, REG_VCC_LO, 32'hFFFF_FFFF);
        sh_execution_mask = 64'h0F0F_F0F0_A5A5_5A5A;
        rdchk(REG_EXECUTION_MASK_HI, 32'h0F0F_F0F0, 1'b0);
        rdchk(REG_VCC_LO, 32'h0000_0000, 1'b0);
        apb(1'b1, REG_IMASK, 32'h0000_0001);
        run(OP_CLASS, PREC_HALF, 6'd63, 64'h0000_0000_0000_7D00, 64'h0000_0000_0000_0001, 1'b0);
        @(posedge mclk);
        #1;
        chk("irq", {63'h0, irq}, 64'h1);
        rdchk(REG_STATUS, 32'h0000_0003, 1'b0);
        apb(1'b1, REG_STATUS, 32'h0000_0001);
        rdchk(REG_STATUS, 32'h0000_0002, 1'b0);
        chk("irq", {63'h0, irq}, 64'h0);
        apb(1'b1, REG_IMASK, 32'h0000_0000);
        run(OP_U, PREC_SINGLE, 6'd0, 64'h0000_0000_7FC0_0000, 64'h0, 1'b1);
        @(posedge mclk);
        #1;
        chk("irq", {63'h0, irq}, 64'h0);
        for (int q = 0; q < 3; q++)
            for (int i = 0; i < 11; i++)
                for (int k = 0; k < 11; k++)
                    run(OP_CLASS, vfc_prec_t'(q), 6'(i * 11 + k), pick(vfc_prec_t'(q), i),
                        k == 10 ? 64'h3FF : 64'h1 << k, k[0]);
        for (int q = 0; q < 2; q++)
            for (o = 1; o < 17; o++)
                for (int i = 0; i < 121; i++)
                    run(vfc_op_t'(o), vfc_prec_t'(q), 6'($random(seed)),
                        pick(vfc_prec_t'(q), i / 11), pick(vfc_prec_t'(q), i % 11), i[0]);
        for (int k = 0; k < 400; k++) begin
            o = $unsigned($random(seed)) % 17;
            p = o == 0 ? vfc_prec_t'($unsigned($random(seed)) % 3) : vfc_prec_t'(k % 2);
            a = {$random(seed), $random(seed)};
            b = o == 0 ? a & 64'h3FF : (k % 3 == 0 ? a : {$random(seed), $random(seed)});
            a = k % 4 == 0 ? pick(p, $unsigned($random(seed)) % 11) : a;
            a = p == PREC_HALF ? a & 64'hFFFF : p == PREC_SINGLE ? a & 64'hFFFF_FFFF : a;
            b = p == PREC_HALF ? b & 64'hFFFF : p == PREC_SINGLE ? b & 64'hFFFF_FFFF : b;
            run(vfc_op_t'(o), p, 6'($random(seed)), a, b, k[1]);
        end
        test_done;
    end
endmodule
`default_nettype wire
